// file: logic/fep_map.svh
`ifndef FEP_MAP_SVH
`define FEP_MAP_SVH

// APB register byte offsets
`define FEP_OFF_STATUS     12'h000
`define FEP_OFF_INTEN      12'h004
`define FEP_OFF_MODE       12'h008
`define FEP_OFF_BC_START   12'h00C
`define FEP_OFF_BC_END     12'h010
`define FEP_OFF_CTRL       12'h014
`define FEP_OFF_CMD_WIN    12'h100

// Status register bit positions
`define FEP_B_ILGL         0
`define FEP_B_ERS          1
`define FEP_B_PRG          2
`define FEP_B_HVE          3
`define FEP_B_CFG          4
`define FEP_B_TBL          5
`define FEP_B_RAM          6
`define FEP_B_OTP          7
`define FEP_B_CODE_AREA_ACCESS_ERR         8
`define FEP_B_DATA_AREA_ACCESS_ERR         9
`define FEP_B_LOCK         10
`define FEP_B_RDY          11
`define FEP_B_SUSP         12
`define FEP_ERR_BITS       10

// Control register bits
`define FEP_C_HVE_A        0
`define FEP_C_HVE_B        1
`define FEP_C_BLANK_CHECK_DIRECTION        2

// Mode entry values
`define FEP_MODE_READ      16'h0000
`define FEP_MODE_DATA_PE   16'h0001
`define FEP_MODE_CODE_PE   16'h0080

// Command codes
`define FEP_CMD_PROGRAM    8'hE8
`define FEP_CMD_DMA_PROG   8'hEA
`define FEP_CMD_CFG_PROG   8'h40
`define FEP_CMD_OTP_SET    8'h45
`define FEP_CMD_ERASE      8'h20
`define FEP_CMD_LOCK_PROG  8'h77
`define FEP_CMD_BLANK      8'h71
`define FEP_CMD_SUSPEND    8'hB0
`define FEP_CMD_RESUME     8'hD0
`define FEP_CMD_CLEAR      8'h50
`define FEP_CMD_STOP       8'hB3
`define FEP_CMD_FINAL      8'hD0

// Expected counts in the second access
`define FEP_N_PROGRAM      8'h80
`define FEP_N_CFG          8'h08
`define FEP_N_OTP          8'h08
`define FEP_N_DMA_MAX      8'h80

`define FEP_ZERO16         16'h0000

`endif

// file: logic/fep_pkg.sv
package fep_pkg;
    typedef enum logic [1:0] {
        FEP_IDLE  = 2'b00,
        FEP_COUNT = 2'b01,
        FEP_FINAL = 2'b11,
        FEP_BUSY  = 2'b10
    } fep_state_e;
endpackage

// file: logic/fep_cmd_guard.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "fep_map.svh"
// Behaviour
// R1: Illegal command, access or fault locks; locked blocks program and erase.
// R2: Lock leaves only on clear or stop with both area flags zero.
// R3: Clear needs ready flag one; stop accepted regardless of ready.
// R4: Lock entry with lock interrupt enabled raises access error interrupt.
// R5: Non-suspend operation completes under lock; suspend then ignored.
// R6: Command while locked sets illegal flag; other flags keep values.
// R7: Mode entry not 0000/0001/0080, or resume mode mismatch, is illegal.
// R8: Undefined code in first write is illegal.
// R9: Final write other than D0 is illegal, except DMA programming.
// R10: Wrong count in second access is illegal; odd DMA count is wrong.
// R11: Blank check with inconsistent direction, start, end is illegal.
// R12: Command in non-accepting mode or unmet conditions sets illegal flag.
// R13: Erase failure or erase of locked block sets erase flag only.
// R14: Program failure or program of locked block sets program flag only.
// R15: Work RAM two-bit ECC error sets only its detect flag.
// R16: Reserved user area in code mode sets illegal and code-area flags.
// R17: Reserved data area or config/OTP reserved target sets data-area flags.
// R18: OTP-set block target, or code mode before authentication, is illegal.
// R19: Window access in read mode, or window read in any mode, is illegal.
// R20: OTP, config and table two-bit ECC errors set their own flags.
// R21: High-voltage enable drop during a command sets high-voltage error flag.
// R22: Read mode is 0000, rejects all commands and locks on attempts.
// R23: Lock release by clear or stop also clears the recorded error flags.
module fep_cmd_guard
    import fep_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Sequencer-side events, from logic on pclk
    input  wire logic              op_done,
    input  wire logic              erase_fail,
    input  wire logic              program_fail,
    input  wire logic              work_ram_ecc_err,
    input  wire logic              otp_ecc_err,
    input  wire logic              config_ecc_err,
    input  wire logic              table_ecc_err,
    input  wire logic              target_lock_protected,
    input  wire logic              target_otp_set,
    input  wire logic              target_reserved,
    input  wire logic              security_released,
    output logic                   pe_start,
    output logic                   pe_suspend,
    output logic                   access_error_irq
);
    if (ADDR_W < 9) begin : g_addr_check
        $error("ADDR_W too small for the window");
    end

    // ==========================================================
    // Registers and state
    fep_state_e                   state;
    fep_state_e                   next_state;
    logic [`FEP_ERR_BITS-1:0]     err;
    logic                         lock_status_flag;
    logic                         lock_int_enable;
    logic [15:0]                  mode_entry_reg;
    logic [15:0]                  suspend_mode;
    logic                         suspended;
    logic [31:0]                  cmd_start_addr;
    logic [31:0]                  cmd_end_addr;
    logic [2:0]                   ctrl;
    logic [7:0]                   cur_cmd;
    logic                         op_by_suspend;

    // ==========================================================
    // APB decode
    // Act only at the completing edge: one effect per transfer
    wire  wr_phase = psel & penable & pready & pwrite;
    wire  rd_phase = psel & penable & pready & ~pwrite;
    wire  hit_stat = paddr == ADDR_W'(`FEP_OFF_STATUS);
    wire  hit_ien  = paddr == ADDR_W'(`FEP_OFF_INTEN);
    wire  hit_mode = paddr == ADDR_W'(`FEP_OFF_MODE);
    wire  hit_bcs  = paddr == ADDR_W'(`FEP_OFF_BC_START);
    wire  hit_bce  = paddr == ADDR_W'(`FEP_OFF_BC_END);
    wire  hit_ctrl = paddr == ADDR_W'(`FEP_OFF_CTRL);
    wire  hit_win  = paddr == ADDR_W'(`FEP_OFF_CMD_WIN);
    wire  mapped   = hit_stat | hit_ien | hit_mode | hit_bcs | hit_bce
                   | hit_ctrl | hit_win;
    wire  win_wr   = wr_phase & hit_win;
    wire  win_rd   = rd_phase & hit_win;
    wire  [7:0] code = pwdata[7:0];

    wire  sequencer_ready_flag = (state != FEP_BUSY);
    wire  high_voltage_enable_a = ctrl[`FEP_C_HVE_A];
    wire  high_voltage_enable_b = ctrl[`FEP_C_HVE_B];
    wire  blank_check_direction = ctrl[`FEP_C_BLANK_CHECK_DIRECTION];
    wire  code_area_access_err = err[`FEP_B_CODE_AREA_ACCESS_ERR];
    wire  data_area_access_err = err[`FEP_B_DATA_AREA_ACCESS_ERR];

    // ==========================================================
    // Mode checks
    wire  mode_read  = mode_entry_reg == `FEP_MODE_READ;           // [R22]
    wire  mode_code  = mode_entry_reg == `FEP_MODE_CODE_PE;
    wire  mode_valid = mode_read | mode_code
                     | (mode_entry_reg == `FEP_MODE_DATA_PE);      // [R7]

    // ==========================================================
    // First-write classification
    wire  is_clear   = code == `FEP_CMD_CLEAR;
    wire  is_stop    = code == `FEP_CMD_STOP;
    wire  is_susp    = code == `FEP_CMD_SUSPEND;
    wire  is_resume  = code == `FEP_CMD_RESUME;
    wire  is_multi   = code == `FEP_CMD_PROGRAM
                     | code == `FEP_CMD_DMA_PROG
                     | code == `FEP_CMD_CFG_PROG
                     | code == `FEP_CMD_OTP_SET;
    wire  is_short   = code == `FEP_CMD_ERASE
                     | code == `FEP_CMD_LOCK_PROG
                     | code == `FEP_CMD_BLANK;
    wire  defined    = is_clear | is_stop | is_susp | is_resume
                     | is_multi | is_short;                        // [R8]
    wire  is_erase   = code == `FEP_CMD_ERASE;
    wire  is_pgm_lb  = code == `FEP_CMD_PROGRAM
                     | code == `FEP_CMD_LOCK_PROG;
    wire  is_cfg_otp = code == `FEP_CMD_CFG_PROG
                     | code == `FEP_CMD_OTP_SET;
    // Descending check scans from high to low address
    wire  bc_bad     = blank_check_direction
                     ? (cmd_start_addr < cmd_end_addr)
                     : (cmd_start_addr > cmd_end_addr);           // [R11]
    wire  resume_bad = is_resume & (~suspended
                     | (suspend_mode != mode_entry_reg));          // [R7]

    // Count check in the second access
    wire  cnt_bad =
        (cur_cmd == `FEP_CMD_DMA_PROG)
            ? (code[0] | code == 8'h00 | code > `FEP_N_DMA_MAX)
        : (cur_cmd == `FEP_CMD_PROGRAM)  ? (code != `FEP_N_PROGRAM)
        : (cur_cmd == `FEP_CMD_CFG_PROG) ? (code != `FEP_N_CFG)
        : (code != `FEP_N_OTP);                                    // [R10]

    // ==========================================================
    // Error detection per window access, in IDLE, COUNT, FINAL and BUSY, plus high-voltage drop in BUSY
    wire  first  = win_wr & state == FEP_IDLE & ~lock_status_flag;
    wire  relock = win_wr & lock_status_flag
                 & ~(is_clear | is_stop);                          // [R6]
    wire  rel_ok = win_wr & lock_status_flag & ~code_area_access_err
                 & ~data_area_access_err
                 & (is_stop | (is_clear & sequencer_ready_flag)); // [R2] [R3]
    wire  blk_lb = first & target_lock_protected & mode_code;
    wire  e_mode = first & (~mode_valid | resume_bad);             // [R7]
    wire  e_read = win_wr & ~lock_status_flag & mode_read;         // [R22]
    wire  e_ilgl = first & ~mode_read & (~defined
                 | (code == `FEP_CMD_BLANK & bc_bad)
                 | (mode_code & ~security_released)                // [R18]
                 | ((is_erase | is_pgm_lb) & target_otp_set));     // [R18]
    wire  e_code_area_access_err = first & mode_code & target_reserved
                 & ~is_cfg_otp;                                    // [R16]
    wire  e_data_area_access_err = first & target_reserved
                 & (is_cfg_otp | ~mode_code);                      // [R17]
    wire  e_ers  = blk_lb & is_erase;                              // [R13]
    wire  e_prg  = blk_lb & is_pgm_lb;                             // [R14]
    wire  e_cnt  = win_wr & state == FEP_COUNT & cnt_bad;          // [R10]
    wire  e_fin  = win_wr & state == FEP_FINAL
                 & code != `FEP_CMD_FINAL;                         // [R9]
    // Busy means a command is in flight; a new write other than suspend or stop is illegal
    wire  e_busy = win_wr & state == FEP_BUSY & ~is_susp & ~is_stop
                 & ~lock_status_flag;                              // [R12]
    wire  e_rdw  = win_rd;                                         // [R19]
    wire  hv_drop = state == FEP_BUSY
                  & ~(high_voltage_enable_a & high_voltage_enable_b);

    wire  any_ilgl = e_mode | e_read | e_ilgl | e_code_area_access_err | e_data_area_access_err | e_cnt
                   | e_fin | e_busy | e_rdw | relock;
    wire  any_err  = any_ilgl | e_ers | e_prg | hv_drop
                   | work_ram_ecc_err | otp_ecc_err | config_ecc_err
                   | table_ecc_err | erase_fail | program_fail;   // [R1]
    wire  first_ok = first & ~any_err;
    wire  start    = (state == FEP_FINAL) & win_wr & ~any_err
                   | first_ok & is_short & ~mode_read;

    // Error flag set vector
    logic [`FEP_ERR_BITS-1:0] err_set;
    assign err_set[`FEP_B_ILGL] = any_ilgl;
    assign err_set[`FEP_B_ERS]  = e_ers | erase_fail;              // [R13]
    assign err_set[`FEP_B_PRG]  = e_prg | program_fail;            // [R14]
    assign err_set[`FEP_B_HVE]  = hv_drop;                         // [R21]
    assign err_set[`FEP_B_CFG]  = config_ecc_err;                  // [R20]
    assign err_set[`FEP_B_TBL]  = table_ecc_err;                   // [R20]
    assign err_set[`FEP_B_RAM]  = work_ram_ecc_err;                // [R15]
    assign err_set[`FEP_B_OTP]  = otp_ecc_err;                     // [R20]
    assign err_set[`FEP_B_CODE_AREA_ACCESS_ERR] = e_code_area_access_err;                          // [R16]
    assign err_set[`FEP_B_DATA_AREA_ACCESS_ERR] = e_data_area_access_err;                          // [R17]

    // ==========================================================
    // Command sequence
    always_comb begin
        next_state = state;
        case (state)
            FEP_IDLE: begin
                if (first_ok & is_multi & ~mode_read)
                    next_state = FEP_COUNT;
                else if (start)
                    next_state = FEP_BUSY;
            end
            FEP_COUNT: begin
                if (lock_status_flag | any_err)
                    next_state = FEP_IDLE;
                else if (win_wr)
                    next_state = (cur_cmd == `FEP_CMD_DMA_PROG)
                               ? FEP_BUSY : FEP_FINAL;             // [R9]
            end
            FEP_FINAL: begin
                if (lock_status_flag | any_err)
                    next_state = FEP_IDLE;
                else if (win_wr)
                    next_state = FEP_BUSY;
            end
            FEP_BUSY: begin
                // Locked operation still runs to its end
                if (op_done | (win_wr & is_stop))
                    next_state = FEP_IDLE;                         // [R5]
            end
            default: next_state = FEP_IDLE;
        endcase
    end

    wire  lock_set = any_err;
    // Set wins over release in the same cycle
    wire  next_lock = lock_set | (lock_status_flag & ~rel_ok);     // [R1] [R2]
    // Suspend honoured only for unlocked non-suspend operations
    wire  susp_ok = win_wr & is_susp & state == FEP_BUSY
                  & ~lock_status_flag & ~op_by_suspend;            // [R5]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state            <= FEP_IDLE;
            cur_cmd          <= 8'h00;
            op_by_suspend    <= 1'b0;
            lock_status_flag <= 1'b0;
        end else begin
            state            <= next_state;
            lock_status_flag <= next_lock;
            if (first_ok)
                cur_cmd <= code;
            if (start)
                op_by_suspend <= (cur_cmd == `FEP_CMD_RESUME);
        end
    end

    // Error flags: release clears, any set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            err <= '0;
        else if (rel_ok)
            err <= err_set;                                        // [R23]
        else
            err <= err | err_set;                                  // [R6]
    end

    // Suspend bookkeeping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suspended    <= 1'b0;
            suspend_mode <= `FEP_ZERO16;
        end else if (susp_ok) begin
            suspended    <= 1'b1;
            suspend_mode <= mode_entry_reg;
        end else if (first_ok & is_resume) begin
            suspended    <= 1'b0;
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_int_enable <= 1'b0;
            mode_entry_reg  <= `FEP_MODE_READ;
            cmd_start_addr  <= 32'h0000_0000;
            cmd_end_addr    <= 32'h0000_0000;
            ctrl            <= 3'h0;
        end else if (wr_phase) begin
            if (hit_ien)
                lock_int_enable <= pwdata[0];
            if (hit_mode)
                mode_entry_reg <= pwdata[15:0];
            if (hit_bcs)
                cmd_start_addr <= pwdata;
            if (hit_bce)
                cmd_end_addr <= pwdata;
            if (hit_ctrl)
                ctrl <= pwdata[2:0];
        end
    end

    // ==========================================================
    // Read mux and outputs
    logic [31:0] rd_status;
    always_comb begin
        rd_status = 32'h0000_0000;
        rd_status[`FEP_ERR_BITS-1:0] = err;
        rd_status[`FEP_B_LOCK] = lock_status_flag;
        rd_status[`FEP_B_RDY]  = sequencer_ready_flag;
        rd_status[`FEP_B_SUSP] = suspended;
    end

    wire  [31:0] next_prdata =
          hit_stat ? rd_status
        : hit_ien  ? {31'h0, lock_int_enable}
        : hit_mode ? {16'h0000, mode_entry_reg}
        : hit_bcs  ? cmd_start_addr
        : hit_bce  ? cmd_end_addr
        : hit_ctrl ? {29'h0, ctrl}
        : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata           <= 32'h0000_0000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            pe_start         <= 1'b0;
            pe_suspend       <= 1'b0;
            access_error_irq <= 1'b0;
        end else begin
            // One wait state: answer one cycle into access phase
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= next_prdata;
            // Locked: no new program or erase starts
            pe_start   <= start & ~lock_status_flag;               // [R1]
            pe_suspend <= susp_ok;
            access_error_irq <= lock_int_enable & next_lock;       // [R4]
        end
    end
endmodule

// file: sim/fep_apb_cpu.sv
`timescale 1ns/1ps
// ==============================
// Processor-side bus master
module fep_apb_cpu
    import fep_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    output logic             done    = 1'b0,
    output logic [31:0]      rdata   = 32'h0,
    output logic             err     = 1'b0,
    output logic             psel    = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite  = 1'b0,
    output logic [11:0]      paddr   = 12'h0,
    output logic [31:0]      pwdata  = 32'h0,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    // Request held until pready is sampled high
    always @(posedge pclk) begin
        done <= psel && penable && pready;
        if (go && !psel) begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= addr;
            pwdata <= wdata;
        end else if (psel && !penable) begin
            penable <= 1'b1;
        end else if (psel && pready) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            rdata   <= prdata;
            err     <= pslverr;
            // Released lines must not keep the old value
            paddr   <= ~paddr;
            pwdata  <= ~pwdata;
        end
    end
endmodule

// file: sim/fep_cmd_guard_props.sv
`timescale 1ns/1ps
`include "fep_map.svh"
// ==============================
// Port checks of the command guard
module fep_cmd_guard_props
    import fep_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              erase_fail,
    input wire logic              program_fail,
    input wire logic              work_ram_ecc_err,
    input wire logic              otp_ecc_err,
    input wire logic              config_ecc_err,
    input wire logic              table_ecc_err,
    input wire logic              pe_start,
    input wire logic              pe_suspend,
    input wire logic              access_error_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire acc    = psel && penable;
    wire wacc   = acc && pwrite;
    wire win    = paddr == `FEP_OFF_CMD_WIN;
    wire fault  = erase_fail || program_fail || work_ram_ecc_err
                  || otp_ecc_err || config_ecc_err || table_ecc_err;
    wire mapped = paddr inside {`FEP_OFF_STATUS, `FEP_OFF_INTEN,
                  `FEP_OFF_MODE, `FEP_OFF_BC_START, `FEP_OFF_BC_END,
                  `FEP_OFF_CTRL, `FEP_OFF_CMD_WIN};

    a_one_wait: assert property (acc && !pready |=> pready)
        else $error("pready missing one cycle into access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_source: assert property (pslverr |-> pready && !mapped)
        else $error("pslverr without unmapped answer");
    a_unmapped_answer: assert property (acc && pready && !mapped
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access answered wrongly");
    a_fault_blocks_start:
        assert property (fault |-> ##2 !pe_start [*4])
        else $error("operation started right after a fault");
    a_irq_cause:
        assert property ($rose(access_error_irq)
        |-> $past(fault || wacc || acc && win))
        else $error("interrupt rose without fault or access");
    a_irq_release:
        assert property ($fell(access_error_irq) |-> $past(wacc))
        else $error("interrupt fell without a write");
    a_suspend_source:
        assert property (pe_suspend
        |-> $past(wacc && win && pwdata[7:0] == 8'hB0))
        else $error("suspend without suspend command");
    a_start_source: assert property (pe_start |-> $past(wacc && win))
        else $error("start without window write");
    a_start_single: assert property (pe_start |=> !pe_start)
        else $error("start pulse repeated");

    c_irq: cover property ($rose(access_error_irq));
    c_start: cover property (pe_start);
    c_slverr: cover property (pready && pslverr);
endmodule

bind fep_cmd_guard fep_cmd_guard_props #(.ADDR_W(ADDR_W)) i_props (.*);

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "fep_map.svh"
module testbench;
    localparam logic [11:0] WIN  = `FEP_OFF_CMD_WIN;
    localparam logic [11:0] MODE = `FEP_OFF_MODE;
    localparam logic [11:0] CTRL = `FEP_OFF_CTRL;
    localparam logic [11:0] INTE = `FEP_OFF_INTEN;
    localparam int EVB [6] = '{`FEP_B_ERS, `FEP_B_PRG, `FEP_B_RAM,
                               `FEP_B_OTP, `FEP_B_CFG, `FEP_B_TBL};
    // {mode, {lock_prot, otp_set, reserved, sec_ok}, code, status}
    localparam logic [39:0] TAB [5] = '{
        {16'h0080, 4'h3, 8'hE8, 12'h501}, {16'h0001, 4'h2, 8'hE8, 12'h601},
        {16'h0001, 4'h2, 8'h40, 12'h601}, {16'h0080, 4'h0, 8'hE8, 12'h401},
        {16'h0080, 4'h5, 8'hE8, 12'h401}};
    // Bad final byte, bad count, odd DMA count, reversed blank range
    localparam logic [23:0] SQ [4] = '{24'hE88055, 24'hE87FD0,
                                       24'hEA0300, 24'h71D000};
    localparam int SN [4] = '{3, 3, 2, 2};
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        go      = 1'b0;
    logic        wr      = 1'b0;
    logic [11:0] addr    = 12'h0;
    logic [31:0] wdata   = 32'h0;
    logic [5:0]  ev      = 6'h0;
    logic [3:0]  tgt     = 4'h0;
    logic        op_done = 1'b0;
    logic        done, err, psel, penable, pwrite, pready, pslverr;
    logic        pe_start, pe_suspend, irq;
    logic [11:0] paddr;
    logic [31:0] rd, pwdata, prdata;
    logic [7:0]  c;
    int          fails = 0, comparisons = 0, starts = 0, susps = 0;
    int          seed  = 89026;

    always #2 pclk = ~pclk;
    // Counted mid-cycle, clear of the launching edge
    always @(negedge pclk) begin
        if (pe_start === 1'b1) starts++;
        if (pe_suspend === 1'b1) susps++;
    end

    fep_cmd_guard i_fep_cmd_guard (
        .*, .erase_fail(ev[0]), .program_fail(ev[1]),
        .work_ram_ecc_err(ev[2]), .otp_ecc_err(ev[3]),
        .config_ecc_err(ev[4]), .table_ecc_err(ev[5]),
        .target_lock_protected(tgt[3]), .target_otp_set(tgt[2]),
        .target_reserved(tgt[1]), .security_released(tgt[0]),
        .access_error_irq(irq));
    fep_apb_cpu i_fep_apb_cpu (.*, .rdata(rd));

    function automatic logic [31:0] evx(input int k);
        return (32'h1 << `FEP_B_LOCK) | (32'h1 << EVB[k]);
    endfunction
    function automatic logic known(input logic [7:0] x);
        return x inside {8'hE8, 8'hEA, 8'h40, 8'h45, 8'h20, 8'h77,
                         8'h71, 8'hB0, 8'hD0, 8'h50, 8'hB3};
    endfunction
    // Area flags keep the lock through a stop command
    function automatic logic [31:0] after_stop(input logic [31:0] e);
        return (e & 32'h300) != 32'h0 ? e : 32'h0;
    endfunction

    task automatic give_verdict;
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (done !== 1'b1 && n < 20);
        if (done !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic st(input logic [31:0] e, input logic [31:0] m = 32'h7FF);
        apb(1'b0, `FEP_OFF_STATUS, 32'h0);
        chk("status", rd & m, e);
    endtask
    task automatic pulse(input int k);
        ev <= 6'h01 << k;
        @(posedge pclk);
        ev <= 6'h00;
        @(posedge pclk);
    endtask
    task automatic prog;
        w(WIN, 32'hE8);
        w(WIN, 32'h80);
        w(WIN, 32'hD0);
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        st(32'h0);
        w(INTE, 32'h1);
        w(WIN, 32'hE8);
        st(32'h401);
        chk("irq", irq, 32'h1);
        w(MODE, 32'h1);
        w(WIN, 32'h50);
        st(32'h0);
        chk("irq", irq, 32'h0);
        apb(1'b0, WIN, 32'h0);
        st(32'h401);
        w(WIN, 32'hB3);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", err, 32'h1);
        chk("rdata", rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            w(INTE, {31'h0, i[0]});
            pulse(i);
            chk("irq", irq, {31'h0, i[0]});
            st(evx(i));
            w(WIN, 32'hE8);
            st(evx(i) | 32'h1);
            w(WIN, 32'hB3);
        end
        for (int i = 0; i < 8; i++) begin
            c = 8'($random(seed));
            if (!known(c)) begin
                w(WIN, {24'h0, c});
                st(32'h401);
                w(WIN, 32'hB3);
            end
        end
        w(`FEP_OFF_BC_START, 32'h200);
        w(`FEP_OFF_BC_END, 32'h100);
        w(CTRL, 32'h3);
        foreach (SQ[j]) begin
            for (int b = 0; b < SN[j]; b++)
                w(WIN, {24'h0, SQ[j][23-8*b -: 8]});
            st(32'h401);
            w(WIN, 32'hB3);
        end
        w(MODE, 32'h81);
        w(WIN, 32'h50);
        st(32'h401);
        w(MODE, 32'h1);
        w(WIN, 32'hB3);
        foreach (TAB[j]) begin
            tgt <= TAB[j][23:20];
            w(MODE, {16'h0, TAB[j][39:24]});
            w(WIN, {24'h0, TAB[j][19:12]});
            st({20'h0, TAB[j][11:0]});
            w(WIN, 32'hB3);
            st(after_stop({20'h0, TAB[j][11:0]}));
            tgt <= 4'h0;
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
        end
        w(MODE, 32'h1);
        w(CTRL, 32'h3);
        prog();
        chk("starts", starts, 32'h1);
        w(WIN, 32'h50);
        st(32'h401);
        w(WIN, 32'hB0);
        chk("suspends", susps, 32'h0);
        w(CTRL, 32'h2);
        st(32'h408, 32'h408);
        op_done <= 1'b1;
        @(posedge pclk);
        op_done <= 1'b0;
        prog();
        chk("starts", starts, 32'h1);
        w(WIN, 32'hB3);
        st(32'h0);
        give_verdict();
    end
endmodule
